/* File: sbie_defines.svh */
// Constants for the skip, branch, increment and OR execution block
`ifndef SBIE_DEFINES_SVH
`define SBIE_DEFINES_SVH
`define SBIE_DATA_W 8
`define SBIE_FADDR_W 7
`define SBIE_TARGET_W 11
`define SBIE_PC_W 13
`define SBIE_LATCH_W 8
`define SBIE_LATCH_LO 3
`define SBIE_LATCH_HI 4
`define SBIE_ACC_RESET 8'h00
`define SBIE_FILE_RESET 8'h00
`define SBIE_PC_RESET 13'h0000
`define SBIE_ZERO_RESET 1'h0
`endif

/* File: sbie_pkg.sv */
// Types shared by the execution block
`include "sbie_defines.svh"
package sbie_pkg;
    typedef enum logic [2:0] {
        SBIE_OP_NONE,
        SBIE_OP_DECREMENT_SKIP_ZERO,
        SBIE_OP_INCREMENT_SKIP_ZERO,
        SBIE_OP_JUMP_ABSOLUTE,
        SBIE_OP_OR_LITERAL_TO_ACC,
        SBIE_OP_INCREMENT_FILE
    } sbie_op_t;

    typedef struct packed {
        sbie_op_t op;
        logic [`SBIE_FADDR_W-1:0] file_addr;
        logic dest_file;
        logic [`SBIE_DATA_W-1:0] literal;
        logic [`SBIE_TARGET_W-1:0] target;
    } sbie_instr_t;

    typedef enum logic [1:0] {
        SBIE_ST_EXEC,
        SBIE_ST_SQUASH,
        SBIE_ST_BRANCH
    } sbie_state_t;
endpackage : sbie_pkg

/* File: sbie_core.sv */
// Execution of skip, branch, increment and OR instructions
`timescale 1ns/10ps
`default_nettype none
`include "sbie_defines.svh"
module sbie_core
    import sbie_pkg::*;
#(
    parameter int FILE_DEPTH = 128
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic instr_valid_in,
    input wire sbie_instr_t instr_in,
    input wire logic [`SBIE_LATCH_W-1:0] pc_high_latch_in,
    output logic instr_ready_out,
    output logic [`SBIE_DATA_W-1:0] acc_out,
    output logic zero_flag_out,
    output logic [`SBIE_PC_W-1:0] pc_out,
    output logic squash_out,
    output logic [`SBIE_DATA_W-1:0] file_rd_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Control state
    sbie_state_t state;
    sbie_state_t next_state;

    // Accumulator, zero flag and program counter
    logic [`SBIE_DATA_W-1:0] acc;
    logic [`SBIE_DATA_W-1:0] next_acc;
    logic zero_flag;
    logic next_zero_flag;
    logic [`SBIE_PC_W-1:0] pc;
    logic [`SBIE_PC_W-1:0] next_pc;

    // File storage and its single write port
    logic [`SBIE_DATA_W-1:0] file_mem [FILE_DEPTH];
    logic file_we;
    logic [`SBIE_DATA_W-1:0] file_wdata;

    // Datapath
    logic [`SBIE_DATA_W-1:0] operand;
    logic [`SBIE_DATA_W-1:0] result;
    logic take;

    // ------------------------------------------------------------
    // Handshake and operand fetch
    // ------------------------------------------------------------
    // Instruction accepted only in the execute state
    // A word offered while refused is dropped, not queued
    assign instr_ready_out = (state == SBIE_ST_EXEC);
    assign take = instr_valid_in && instr_ready_out;
    assign operand = file_mem[instr_in.file_addr];

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Route a result to acc or file by destination bit
    function automatic logic route_to_file(input logic dest);
        return dest;
    endfunction : route_to_file

    // Zero test shared by the skips and the zero flag
    function automatic logic is_zero(input logic [`SBIE_DATA_W-1:0] value);
        return (value == '0);
    endfunction : is_zero

    // ------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------
    // Next-value logic for every instruction
    // Ready gates every change a word makes, so a refused word leaves no trace
    always_comb begin
        next_state = state;
        next_acc = acc;
        next_zero_flag = zero_flag;
        next_pc = pc;
        file_we = 1'h0;
        file_wdata = operand;
        result = operand;
        unique case (state)
            SBIE_ST_EXEC: begin
                if (take) begin
                    // Taken words advance pc, except jumps (target) and unused codes (pc held)
                    next_pc = pc + `SBIE_PC_W'(1);
                    unique case (instr_in.op)
                        SBIE_OP_DECREMENT_SKIP_ZERO: begin
                            result = operand - 8'h01;
                            if (route_to_file(instr_in.dest_file)) begin
                                file_we = 1'h1;
                            end else begin
                                next_acc = result;
                            end
                            if (is_zero(result)) begin
                                next_state = SBIE_ST_SQUASH;
                            end
                        end
                        SBIE_OP_INCREMENT_SKIP_ZERO: begin
                            result = operand + 8'h01;
                            if (route_to_file(instr_in.dest_file)) begin
                                file_we = 1'h1;
                            end else begin
                                next_acc = result;
                            end
                            if (is_zero(result)) begin
                                next_state = SBIE_ST_SQUASH;
                            end
                        end
                        SBIE_OP_JUMP_ABSOLUTE: begin
                            next_pc = {pc_high_latch_in[`SBIE_LATCH_HI:`SBIE_LATCH_LO],
                                       instr_in.target};
                            next_state = SBIE_ST_BRANCH;
                        end
                        SBIE_OP_OR_LITERAL_TO_ACC: begin
                            result = acc | instr_in.literal;
                            next_acc = result;
                            next_zero_flag = is_zero(result);
                        end
                        SBIE_OP_INCREMENT_FILE: begin
                            result = operand + 8'h01;
                            if (route_to_file(instr_in.dest_file)) begin
                                file_we = 1'h1;
                            end else begin
                                next_acc = result;
                            end
                            next_zero_flag = is_zero(result);
                        end
                        default: begin
                            // Unused codes act as a no-op with pc held
                            next_pc = pc;
                        end
                    endcase
                    // One write port, fed by the routed result
                    file_wdata = result;
                end
            end
            SBIE_ST_SQUASH: begin
                // Skipped word consumed as a no-op
                next_pc = pc + `SBIE_PC_W'(1);
                next_state = SBIE_ST_EXEC;
            end
            SBIE_ST_BRANCH: begin
                // Refill slot after the branch
                next_state = SBIE_ST_EXEC;
            end
        endcase
    end

    // Register the core state
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state <= SBIE_ST_EXEC;
            acc <= `SBIE_ACC_RESET;
            zero_flag <= `SBIE_ZERO_RESET;
            pc <= `SBIE_PC_RESET;
        end else begin
            state <= next_state;
            acc <= next_acc;
            zero_flag <= next_zero_flag;
            pc <= next_pc;
        end
    end

    // ------------------------------------------------------------
    // File registers
    // ------------------------------------------------------------
    // Flop storage; reset clears so reads are defined
    genvar gi;
    generate
        for (gi = 0; gi < FILE_DEPTH; gi++) begin : g_file
            logic [`SBIE_DATA_W-1:0] next_file;
            // Only the addressed entry takes the write
            always_comb begin
                next_file = file_mem[gi];
                if (file_we && (instr_in.file_addr == `SBIE_FADDR_W'(gi))) begin
                    next_file = file_wdata;
                end
            end
            // Register the entry
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    file_mem[gi] <= `SBIE_FILE_RESET;
                end else begin
                    file_mem[gi] <= next_file;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Data outputs straight from flops
    assign acc_out = acc;
    assign zero_flag_out = zero_flag;
    assign pc_out = pc;
    assign squash_out = (state == SBIE_ST_SQUASH); // Marks the no-op slot
    // Read port follows the offered address, hence not a flop
    assign file_rd_out = file_mem[instr_in.file_addr];

endmodule : sbie_core
`default_nettype wire

/* File: sbie_core_asserts.sv */
// Assertion checker for the execution block ports
`timescale 1ns/10ps
`default_nettype none
module sbie_core_asserts
    import sbie_pkg::*;
#(
    parameter int FILE_DEPTH = 128
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic instr_valid_in,
    input wire sbie_instr_t instr_in,
    input wire logic [7:0] pc_high_latch_in,
    input wire logic instr_ready_out,
    input wire logic [7:0] acc_out,
    input wire logic zero_flag_out,
    input wire logic [12:0] pc_out,
    input wire logic squash_out,
    input wire logic [7:0] file_rd_out
);
    // ----
    // Results expected after a taking edge
    // ----
    logic [12:0] jt;
    logic [7:0] orv, inc, dec;
    wire logic tk = instr_valid_in && instr_ready_out;
    wire logic jmp = tk && instr_in.op == SBIE_OP_JUMP_ABSOLUTE;
    wire logic orl = tk && instr_in.op == SBIE_OP_OR_LITERAL_TO_ACC;
    wire logic inf = tk && instr_in.op == SBIE_OP_INCREMENT_FILE;
    wire logic dsz = tk && instr_in.op == SBIE_OP_DECREMENT_SKIP_ZERO;
    wire logic isz = tk && instr_in.op == SBIE_OP_INCREMENT_SKIP_ZERO;
    always_ff @(posedge clk_in) begin
        jt <= {pc_high_latch_in[4:3], instr_in.target};
        orv <= acc_out | instr_in.literal;
        inc <= file_rd_out + 8'h01;
        dec <= file_rd_out - 8'h01;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    chk_jump_target: assert property (
        jmp |=> pc_out == jt) else $error("jump target wrong");
    chk_jump_refill: assert property (
        jmp |=> !instr_ready_out ##1 instr_ready_out) else $error("jump cycles wrong");
    chk_or_result: assert property (
        orl |=> acc_out == orv && zero_flag_out == (orv == 8'h00)) else $error("or wrong");
    chk_increment_file_acc: assert property (
        inf && !instr_in.dest_file |=> acc_out == inc && zero_flag_out == (inc == 8'h00))
        else $error("increment wrong");
    chk_single_cycle: assert property (
        inf || orl |=> instr_ready_out && !squash_out) else $error("not single cycle");
    chk_skip_flags: assert property (
        dsz || isz |=> $stable(zero_flag_out)) else $error("skip touched zero flag");
    chk_dec_acc: assert property (
        dsz && !instr_in.dest_file |=> acc_out == dec) else $error("decrement wrong");
    chk_dec_skip: assert property (
        dsz |=> squash_out == (dec == 8'h00)) else $error("decrement skip wrong");
    chk_inc_skip: assert property (
        isz |=> squash_out == (inc == 8'h00)) else $error("increment skip wrong");
    chk_isz_acc: assert property (
        isz && !instr_in.dest_file |=> acc_out == inc) else $error("increment skip result wrong");
    chk_file_dest: assert property (
        (dsz || isz || inf) && instr_in.dest_file |=> $stable(acc_out))
        else $error("file destination touched acc");
    cover property (jmp);
    cover property (dsz ##1 squash_out);
    cover property (orl);
    cover property (isz ##1 squash_out);
endmodule : sbie_core_asserts
`default_nettype wire

/* File: sbie_core_tb.sv */
// Self-checking testbench for the execution block
`timescale 1ns/10ps
`default_nettype none
module sbie_core_tb
    import sbie_pkg::*;
;
    // ----
    // Stimulus and checks
    // ----
    logic clk_in = 1'h0, reset_in = 1'h1, instr_valid_in = 1'h0;
    sbie_instr_t instr_in = '0;
    logic [7:0] pc_high_latch_in = 8'h00, acc_out, file_rd_out;
    logic instr_ready_out, zero_flag_out, squash_out;
    logic [12:0] pc_out;
    int num_errors = 0, n_tests = 0;
    sbie_core #(.FILE_DEPTH(128)) sbie_core_i (.clk_in(clk_in), .reset_in(reset_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in), .pc_high_latch_in(pc_high_latch_in),
        .instr_ready_out(instr_ready_out), .acc_out(acc_out), .zero_flag_out(zero_flag_out),
        .pc_out(pc_out), .squash_out(squash_out), .file_rd_out(file_rd_out));
    initial forever #10 clk_in = ~clk_in;
    // Wide enough for every packed group compared below
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One instruction; waits out refused cycles, ends at the following falling edge
    task go(input sbie_op_t op, input logic [6:0] a, input logic d, input logic [7:0] l,
            input logic [10:0] t);
        repeat (4) if (instr_ready_out !== 1'h1) @(negedge clk_in);
        @(posedge clk_in);
        instr_valid_in <= 1'h1;
        instr_in <= '{op, a, d, l, t};
        @(posedge clk_in);
        instr_valid_in <= 1'h0;
        @(negedge clk_in);
    endtask : go
    task t_increment_file;
        go(SBIE_OP_INCREMENT_FILE, 7'h09, 1'h1, 8'h00, 11'h000);
        check(32'(file_rd_out), 32'h00000001);
        go(SBIE_OP_DECREMENT_SKIP_ZERO, 7'h09, 1'h1, 8'h00, 11'h000);
        check(32'(squash_out), 32'h00000001);
        go(SBIE_OP_DECREMENT_SKIP_ZERO, 7'h09, 1'h1, 8'h00, 11'h000);
        go(SBIE_OP_INCREMENT_FILE, 7'h09, 1'h0, 8'h00, 11'h000);
        check(32'({acc_out, zero_flag_out, file_rd_out}), 32'h000001FF);
    endtask : t_increment_file
    task t_dec;
        go(SBIE_OP_DECREMENT_SKIP_ZERO, 7'h05, 1'h1, 8'h00, 11'h000);
        check(32'({file_rd_out, squash_out, zero_flag_out}), 32'h000003FD);
        go(SBIE_OP_DECREMENT_SKIP_ZERO, 7'h05, 1'h0, 8'h00, 11'h000);
        check(32'({acc_out, file_rd_out}), 32'h0000FEFF);
    endtask : t_dec
    task t_isz;
        go(SBIE_OP_INCREMENT_SKIP_ZERO, 7'h05, 1'h0, 8'h00, 11'h000);
        check(32'({acc_out, squash_out, instr_ready_out, zero_flag_out}), 32'h00000005);
        go(SBIE_OP_INCREMENT_SKIP_ZERO, 7'h05, 1'h1, 8'h00, 11'h000);
        check(32'({file_rd_out, squash_out}), 32'h00000001);
        go(SBIE_OP_INCREMENT_SKIP_ZERO, 7'h05, 1'h1, 8'h00, 11'h000);
        check(32'({file_rd_out, squash_out}), 32'h00000002);
    endtask : t_isz
    task t_or;
        go(SBIE_OP_OR_LITERAL_TO_ACC, 7'h00, 1'h0, 8'hA5, 11'h000);
        check(32'({acc_out, zero_flag_out}), 32'h0000014A);
        go(SBIE_OP_OR_LITERAL_TO_ACC, 7'h00, 1'h0, 8'h5A, 11'h000);
        check(32'({acc_out, zero_flag_out}), 32'h000001FE);
    endtask : t_or
    task jp(input logic [7:0] lat, input logic [10:0] t, input logic [12:0] exp);
        @(posedge clk_in);
        pc_high_latch_in <= lat;
        go(SBIE_OP_JUMP_ABSOLUTE, 7'h00, 1'h0, 8'h00, t);
        check(32'({pc_out, instr_ready_out}), 32'({exp, 1'h0}));
    endtask : jp
    // Unused op code: pc holds the branch target, no refill
    task t_none;
        go(SBIE_OP_NONE, 7'h00, 1'h0, 8'h00, 11'h000);
        check(32'({pc_out, instr_ready_out}), 32'h00000AAB);
    endtask : t_none
    // Mid-run reset clears file 9, then OR of zero sets the flag
    task t_reset;
        @(posedge clk_in);
        reset_in <= 1'h1;
        instr_in <= '{SBIE_OP_NONE, 7'h09, 1'h0, 8'h00, 11'h000};
        repeat (3) @(posedge clk_in);
        reset_in <= 1'h0;
        @(negedge clk_in);
        check(32'({acc_out, zero_flag_out, pc_out, squash_out, instr_ready_out}), 32'h00000001);
        check(32'(file_rd_out), 32'h00000000);
        go(SBIE_OP_OR_LITERAL_TO_ACC, 7'h00, 1'h0, 8'h00, 11'h000);
        check(32'({acc_out, zero_flag_out}), 32'h00000001);
    endtask : t_reset
    task conclude;
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (10) @(posedge clk_in);
        reset_in <= 1'h0;
        @(negedge clk_in);
        check(32'({acc_out, zero_flag_out, pc_out, squash_out}), 32'h00000000);
        t_increment_file;
        t_dec;
        t_isz;
        t_or;
        jp(8'h18, 11'h7FF, 13'h1FFF);
        jp(8'hE7, 11'h555, 13'h0555);
        t_none;
        t_reset;
        conclude;
    end
    initial begin
        #(20 * 3000);
        num_errors++;
        conclude;
    end
endmodule : sbie_core_tb
bind sbie_core sbie_core_asserts #(.FILE_DEPTH(FILE_DEPTH)) sbie_core_asserts_i (
    .clk_in(clk_in), .reset_in(reset_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .pc_high_latch_in(pc_high_latch_in), .instr_ready_out(instr_ready_out),
    .acc_out(acc_out), .zero_flag_out(zero_flag_out), .pc_out(pc_out),
    .squash_out(squash_out), .file_rd_out(file_rd_out));
`default_nettype wire
